//--- adc_mode_config_port.sv
// adc_mode_config_port: parallel straps or serial port for converter modes
`timescale 1ns/1ps
`default_nettype none
module adc_mode_config_port (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic programming_select_pin,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic sdi,
	input wire logic sample_tick,
	output logic sdo_o,
	output logic sdo_oe,
	output logic digital_out_en,
	output logic core_power_en,
	output logic ref_power_en,
	output logic nap_recovering,
	output logic dcs_on,
	output logic [1:0] out_mode,
	output logic [2:0] lvds_current,
	output logic term_on,
	output logic clk_inv,
	output logic [1:0] clk_phase,
	output logic [5:0] data_format
);
	mode_cfg_pkg::pins_t sync1_r;
	mode_cfg_pkg::pins_t sync2_r;
	logic sck_prev_r;
	logic [7:0] power_r;
	logic [7:0] timing_r;
	logic [7:0] outmode_r;
	logic [7:0] format_r;
	logic [4:0] bit_cnt_r;
	logic [14:0] shift_r;
	logic [7:0] read_r;
	logic reading_r;
	logic soft_reset_r;
	logic [6:0] nap_cnt_r;
	mode_cfg_pkg::mode_t mode_nxt;
	mode_cfg_pkg::power_state_t pwr_prev_r;

	wire logic parallel = sync2_r.prog_sel;
	wire logic frame = ~parallel & ~sync2_r.cs_n;
	wire logic sck_rise = sync2_r.sck & ~sck_prev_r;
	wire logic sck_fall = ~sync2_r.sck & sck_prev_r;
	wire logic [15:0] word = {shift_r, sync2_r.sdi};
	wire logic take_bit = frame && sck_rise
		&& bit_cnt_r < mode_cfg_pkg::WORD_BITS_C;
	wire logic shift_out = frame && sck_fall
		&& bit_cnt_r > mode_cfg_pkg::DATA_START
		&& bit_cnt_r < mode_cfg_pkg::WORD_BITS_C;
	wire logic wr_strobe = take_bit && bit_cnt_r == 5'h0F
		&& !word[15];
	wire logic nap_exit = pwr_prev_r == mode_cfg_pkg::PWR_NAP
		&& mode_nxt.power == mode_cfg_pkg::PWR_NORMAL;

	function automatic logic [7:0] reg_read(input logic [6:0] addr,
		input logic [7:0] pw, input logic [7:0] tm, input logic [7:0] om,
		input logic [7:0] fm);
		unique case (addr)
			mode_cfg_pkg::ADDR_POWER: reg_read = pw;
			mode_cfg_pkg::ADDR_TIMING: reg_read = tm;
			mode_cfg_pkg::ADDR_OUTMODE: reg_read = om;
			mode_cfg_pkg::ADDR_FORMAT: reg_read = fm;
			default: reg_read = mode_cfg_pkg::REG_RESET_VAL;
		endcase
	endfunction

	// address match for a completed write word
	function automatic logic wr_hit(input logic strobe,
		input logic [6:0] addr, input logic [6:0] target);
		wr_hit = strobe && addr == target;
	endfunction

	// pins pass two flip-flops
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			sync1_r <= '{cs_n: 1'b1, default: 1'b0};
			sync2_r <= '{cs_n: 1'b1, default: 1'b0};
			sck_prev_r <= 1'b0;
		end else begin
			sync1_r <= '{cs_n: cs_n, sck: sck, sdi: sdi,
				prog_sel: programming_select_pin};
			sync2_r <= sync1_r;
			sck_prev_r <= sync2_r.sck;
		end
	end

	// bit counter, later rises ignored
	always_ff @(posedge ref_clk) begin
		if (!resetn || !frame)
			bit_cnt_r <= 5'h00;
		else if (take_bit)
			bit_cnt_r <= bit_cnt_r + 5'h01;
	end

	// input shift register, first bit first
	always_ff @(posedge ref_clk) begin
		if (!resetn || !frame)
			shift_r <= '0;
		else if (take_bit)
			shift_r <= word[14:0];
	end

	// read flag from the first bit
	always_ff @(posedge ref_clk) begin
		if (!resetn || !frame)
			reading_r <= 1'b0;
		else if (take_bit && bit_cnt_r == 5'h00)
			reading_r <= sync2_r.sdi;
	end

	// read data, loaded after the address, shifted on falls
	always_ff @(posedge ref_clk) begin
		if (!resetn || !frame)
			read_r <= '0;
		else if (take_bit && bit_cnt_r == 5'h07 && reading_r)
			read_r <= reg_read(word[6:0], power_r, timing_r, outmode_r,
				format_r);
		else if (shift_out)
			read_r <= {read_r[6:0], 1'b0};
	end

	// open drain data, never driven high
	always_ff @(posedge ref_clk) begin
		if (!resetn)
			sdo_o <= 1'b0;
		else
			sdo_o <= 1'b0;
	end

	// pull low while the current read bit is zero
	always_ff @(posedge ref_clk) begin
		if (!resetn)
			sdo_oe <= 1'b0;
		else
			sdo_oe <= frame && reading_r
				&& bit_cnt_r >= mode_cfg_pkg::DATA_START
				&& !read_r[7];
	end

	// software reset pulse, clears itself next cycle
	always_ff @(posedge ref_clk) begin
		if (!resetn || soft_reset_r)
			soft_reset_r <= 1'b0;
		else if (wr_hit(wr_strobe, word[14:8], mode_cfg_pkg::ADDR_RESET))
			soft_reset_r <= word[mode_cfg_pkg::RESET_BIT];
	end

	// power down register
	always_ff @(posedge ref_clk) begin
		if (!resetn || soft_reset_r)
			power_r <= mode_cfg_pkg::REG_RESET_VAL;
		else if (wr_hit(wr_strobe, word[14:8], mode_cfg_pkg::ADDR_POWER))
			power_r <= word[7:0];
	end

	// timing register
	always_ff @(posedge ref_clk) begin
		if (!resetn || soft_reset_r)
			timing_r <= mode_cfg_pkg::REG_RESET_VAL;
		else if (wr_hit(wr_strobe, word[14:8], mode_cfg_pkg::ADDR_TIMING))
			timing_r <= word[7:0];
	end

	// output mode register
	always_ff @(posedge ref_clk) begin
		if (!resetn || soft_reset_r)
			outmode_r <= mode_cfg_pkg::REG_RESET_VAL;
		else if (wr_hit(wr_strobe, word[14:8], mode_cfg_pkg::ADDR_OUTMODE))
			outmode_r <= word[7:0];
	end

	// data format register
	always_ff @(posedge ref_clk) begin
		if (!resetn || soft_reset_r)
			format_r <= mode_cfg_pkg::REG_RESET_VAL;
		else if (wr_hit(wr_strobe, word[14:8], mode_cfg_pkg::ADDR_FORMAT))
			format_r <= word[7:0];
	end

	// mode selection: parallel straps or serial registers
	always_comb begin
		mode_nxt = '0;
		if (parallel) begin
			mode_nxt.dcs_on = sync2_r.cs_n;
			mode_nxt.out_mode = sync2_r.sck ? mode_cfg_pkg::OUTMODE_LVDS
				: mode_cfg_pkg::OUTMODE_CMOS;
			mode_nxt.lvds_current = mode_cfg_pkg::ILVDS_3P5;
			mode_nxt.term_on = 1'b0;
			mode_nxt.power = sync2_r.sdi ? mode_cfg_pkg::PWR_SLEEP
				: mode_cfg_pkg::PWR_NORMAL;
		end else begin
			mode_nxt.dcs_on = timing_r[mode_cfg_pkg::DCS_BIT];
			mode_nxt.clk_phase = timing_r[2:1];
			mode_nxt.clk_inv = timing_r[3];
			mode_nxt.out_mode = outmode_r[1:0];
			mode_nxt.outputs_off = outmode_r[mode_cfg_pkg::OUTPUT_DISABLE_BIT_BIT];
			mode_nxt.term_on = outmode_r[3];
			mode_nxt.lvds_current = outmode_r[6:4];
			mode_nxt.data_format = format_r[5:0];
			unique case (power_r[1:0])
				mode_cfg_pkg::PD_NAP: mode_nxt.power = mode_cfg_pkg::PWR_NAP;
				mode_cfg_pkg::PD_SLEEP: mode_nxt.power = mode_cfg_pkg::PWR_SLEEP;
				default: mode_nxt.power = mode_cfg_pkg::PWR_NORMAL;
			endcase
		end
	end

	// digital outputs driven unless disabled
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			digital_out_en <= 1'b0;
		end else begin
			digital_out_en <= !mode_nxt.outputs_off;
		end
	end

	// core powered only in normal operation
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			core_power_en <= 1'b0;
		end else begin
			core_power_en <= mode_nxt.power == mode_cfg_pkg::PWR_NORMAL;
		end
	end

	// references stay up except in sleep
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			ref_power_en <= 1'b0;
		end else begin
			ref_power_en <= mode_nxt.power != mode_cfg_pkg::PWR_SLEEP;
		end
	end

	// power state of the previous cycle
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			pwr_prev_r <= mode_cfg_pkg::PWR_NORMAL;
		end else begin
			pwr_prev_r <= mode_nxt.power;
		end
	end

	// duty cycle stabilizer
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			dcs_on <= 1'b0;
		end else begin
			dcs_on <= mode_nxt.dcs_on;
		end
	end

	// output mode select
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			out_mode <= 2'h0;
		end else begin
			out_mode <= mode_nxt.out_mode;
		end
	end

	// lvds drive current
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			lvds_current <= 3'h0;
		end else begin
			lvds_current <= mode_nxt.lvds_current;
		end
	end

	// internal termination
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			term_on <= 1'b0;
		end else begin
			term_on <= mode_nxt.term_on;
		end
	end

	// output clock invert
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			clk_inv <= 1'b0;
		end else begin
			clk_inv <= mode_nxt.clk_inv;
		end
	end

	// output clock phase
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			clk_phase <= 2'h0;
		end else begin
			clk_phase <= mode_nxt.clk_phase;
		end
	end

	// data format settings
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			data_format <= 6'h00;
		end else begin
			data_format <= mode_nxt.data_format;
		end
	end

	// nap recovery counter in sample clock ticks
	always_ff @(posedge ref_clk) begin
		if (!resetn)
			nap_cnt_r <= 7'h00;
		else if (nap_exit)
			nap_cnt_r <= mode_cfg_pkg::NAP_RECOVER_C;
		else if (nap_cnt_r != 7'h00 && sample_tick)
			nap_cnt_r <= nap_cnt_r - 7'h01;
	end

	// recovering until the last tick is counted
	always_ff @(posedge ref_clk) begin
		if (!resetn)
			nap_recovering <= 1'b0;
		else if (nap_exit)
			nap_recovering <= 1'b1;
		else
			nap_recovering <= nap_cnt_r != 7'h00
				&& !(sample_tick && nap_cnt_r == 7'h01);
	end
endmodule // adc_mode_config_port
`default_nettype wire

//--- mode_cfg_pkg.sv
// package: register map, field positions and mode types of the mode port
package mode_cfg_pkg;
	localparam logic [6:0] ADDR_RESET = 7'h00;
	localparam logic [6:0] ADDR_POWER = 7'h01;
	localparam logic [6:0] ADDR_TIMING = 7'h02;
	localparam logic [6:0] ADDR_OUTMODE = 7'h03;
	localparam logic [6:0] ADDR_FORMAT = 7'h04;
	localparam logic [7:0] REG_RESET_VAL = 8'h00;
	localparam int RESET_BIT = 7;
	localparam int OUTPUT_DISABLE_BIT_BIT = 2;
	localparam int DCS_BIT = 0;
	localparam int WORD_BITS = 16;
	localparam logic [4:0] WORD_BITS_C = 5'h10;
	localparam logic [4:0] DATA_START = 5'h08;
	localparam logic [1:0] PD_NORMAL = 2'h0;
	localparam logic [1:0] PD_NAP = 2'h1;
	localparam logic [1:0] PD_SLEEP = 2'h3;
	localparam logic [1:0] OUTMODE_CMOS = 2'h0;
	localparam logic [1:0] OUTMODE_LVDS = 2'h1;
	localparam logic [2:0] ILVDS_3P5 = 3'h0;
	localparam int NAP_RECOVER_CYCLES = 100;
	localparam logic [6:0] NAP_RECOVER_C = 7'h64;

	typedef enum logic [1:0] {
		PWR_NORMAL = 2'b00,
		PWR_NAP = 2'b01,
		PWR_SLEEP = 2'b10
	} power_state_t;

	typedef struct packed {
		logic cs_n;
		logic sck;
		logic sdi;
		logic prog_sel;
	} pins_t;

	typedef struct packed {
		power_state_t power;
		logic outputs_off;
		logic dcs_on;
		logic [1:0] out_mode;
		logic [2:0] lvds_current;
		logic term_on;
		logic clk_inv;
		logic [1:0] clk_phase;
		logic [5:0] data_format;
	} mode_t;
endpackage

//--- mode_port_sva.sv
// checker: assertions on the mode port pins
`timescale 1ns/1ps
`default_nettype none
module mode_port_sva (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic programming_select_pin,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic sdi,
	input wire logic sample_tick,
	input wire logic sdo_o,
	input wire logic sdo_oe,
	input wire logic digital_out_en,
	input wire logic core_power_en,
	input wire logic ref_power_en,
	input wire logic nap_recovering,
	input wire logic dcs_on,
	input wire logic [1:0] out_mode,
	input wire logic term_on
);
	logic [7:0] tick_r;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	// sample ticks seen during nap recovery
	always_ff @(posedge ref_clk) begin
		if (!nap_recovering)
			tick_r <= 8'h00;
		else if (sample_tick)
			tick_r <= tick_r + 8'h01;
	end
	a_sdo_pull_low: assert property (sdo_o == 1'b0)
		else $error("sdo high");
	a_par_dcs: assert property ((programming_select_pin && $stable(cs_n))[*5]
		|-> dcs_on == cs_n) else $error("dcs strap");
	a_par_mode: assert property ((programming_select_pin && $stable(sck))[*5]
		|-> out_mode == {1'b0, sck} && !term_on) else $error("mode strap");
	a_par_sleep: assert property ((programming_select_pin && $stable(sdi))[*5]
		|-> {core_power_en, ref_power_en} == {2{!sdi}}) else $error("sleep");
	a_par_awake: assert property ((programming_select_pin && !sdi)[*5]
		|-> digital_out_en) else $error("outputs off");
	a_par_no_nap: assert property (programming_select_pin[*5]
		|-> core_power_en || !ref_power_en) else $error("nap strap");
	a_sleep_all: assert property (!ref_power_en |-> !core_power_en)
		else $error("core on in sleep");
	a_nap_max: assert property (nap_recovering |-> tick_r <= 8'h64)
		else $error("recovery long");
	a_nap_min: assert property ($fell(nap_recovering) |-> tick_r == 8'h64)
		else $error("recovery short");
	c_nap_exit: cover property ($fell(nap_recovering));
	c_read: cover property (sdo_oe);
	c_par_sleep: cover property (programming_select_pin && !ref_power_en);
endmodule // mode_port_sva
bind adc_mode_config_port mode_port_sva u_mode_port_sva (.ref_clk, .resetn,
	.programming_select_pin, .cs_n, .sck, .sdi, .sample_tick, .sdo_o, .sdo_oe,
	.digital_out_en, .core_power_en, .ref_power_en, .nap_recovering, .dcs_on,
	.out_mode, .term_on);
`default_nettype wire

//--- host_model.sv
// host model: straps and serial words, open-drain read back
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input wire logic ref_clk,
	input wire logic sdo_oe,
	output var logic programming_select_pin,
	output var logic cs_n,
	output var logic sck,
	output var logic sdi
);
	initial {programming_select_pin, cs_n, sck, sdi} = 4'hC;
	task automatic straps(input logic [2:0] v);
		@(posedge ref_clk);
		programming_select_pin <= 1'b1;
		{cs_n, sck, sdi} <= v;
	endtask
	// fewer than 16 rises aborts the word, more adds surplus rises
	task automatic xfer(input logic [15:0] w, input int nb, input int h,
		output logic [7:0] rd);
		@(posedge ref_clk);
		programming_select_pin <= 1'b0;
		@(posedge ref_clk);
		cs_n <= 1'b0;
		for (int i = 0; i < nb; i++) begin
			@(posedge ref_clk);
			sck <= 1'b0;
			sdi <= (i < 16) ? w[15 - i] : 1'b1;
			repeat (h) @(posedge ref_clk);
			sck <= 1'b1;
			repeat (h - 1) @(posedge ref_clk);
			if (i >= 8)
				rd = {rd[6:0], !sdo_oe};
		end
		@(posedge ref_clk);
		sck <= 1'b0;
		sdi <= !sdi;
		cs_n <= 1'b1;
		repeat (8) @(posedge ref_clk);
	endtask
endmodule // host_model
`default_nettype wire

//--- testbench.sv
// testbench: self-checking run of the mode port
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; \
	$display("ERROR %0t got %h exp %h", $time, a, b); end end
module testbench;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic sample_tick = 1'b0;
	logic programming_select_pin, cs_n, sck, sdi, sdo_oe, digital_out_en;
	logic core_power_en, ref_power_en, nap_recovering, dcs_on, term_on, clk_inv;
	logic [1:0] out_mode, clk_phase;
	logic [2:0] lvds_current;
	logic [7:0] rd;
	logic sdo_o;
	logic [5:0] data_format;
	int err_count = 0;
	int n_tests = 0;
	int cyc = 0;
	always #10 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		sample_tick <= (cyc % 4 == 3);
		if (cyc == 20000) begin
			err_count++;
			wrap_up();
		end
	end
	host_model u_host_model (.ref_clk, .sdo_oe, .programming_select_pin,
		.cs_n, .sck, .sdi);
	adc_mode_config_port u_adc_mode_config_port (.ref_clk, .resetn,
		.programming_select_pin, .cs_n, .sck, .sdi, .sample_tick, .sdo_o,
		.sdo_oe, .digital_out_en, .core_power_en, .ref_power_en, .nap_recovering,
		.dcs_on, .out_mode, .lvds_current, .term_on, .clk_inv, .clk_phase,
		.data_format);
	task automatic wr(input logic [6:0] a, input logic [7:0] d, input int nb = 16,
		input int h = 4);
		u_host_model.xfer({1'b0, a, d}, nb, h, rd);
	endtask
	task automatic rchk(input logic [6:0] a, input logic [7:0] e);
		u_host_model.xfer({1'b1, a, 8'hFF}, 16, 4, rd);
		`CHK(rd, e)
		`CHK(sdo_o, 1'b0)
	endtask
	task automatic t_parallel();
		for (int v = 0; v < 8; v++) begin
			u_host_model.straps(v[2:0]);
			repeat (6) @(posedge ref_clk);
			`CHK(dcs_on, v[2])
			`CHK(out_mode, {1'b0, v[1]})
			if (v[1]) `CHK({lvds_current, term_on}, 4'h0)
			`CHK({core_power_en, ref_power_en}, {2{!v[0]}})
		end
	endtask
	task automatic t_soft_reset();
		wr(mode_cfg_pkg::ADDR_RESET, 8'h80);
		wr(mode_cfg_pkg::ADDR_FORMAT, 8'h2A);
		`CHK(data_format, 6'h2A)
		wr(mode_cfg_pkg::ADDR_OUTMODE, 8'h04);
		`CHK(digital_out_en, 1'b0)
		wr(mode_cfg_pkg::ADDR_RESET, 8'h80);
		`CHK(digital_out_en, 1'b1)
		`CHK(data_format, 6'h00)
		rchk(mode_cfg_pkg::ADDR_OUTMODE, 8'h00);
		rchk(mode_cfg_pkg::ADDR_RESET, 8'h00);
	endtask
	task automatic t_power();
		logic [1:0] s [4] = '{2'h0, 2'h3, 2'h2, 2'h1};
		for (int c = 0; c < 4; c++) begin
			wr(mode_cfg_pkg::ADDR_POWER, {6'h3F, s[c]});
			`CHK({core_power_en, ref_power_en}, {s[c][0] == 1'b0, s[c] != 2'h3})
		end
		wr(mode_cfg_pkg::ADDR_POWER, 8'h00);
		`CHK(nap_recovering, 1'b1)
		repeat (370) @(posedge ref_clk);
		`CHK(nap_recovering, 1'b1)
		repeat (50) @(posedge ref_clk);
		`CHK(nap_recovering, 1'b0)
	endtask
	task automatic t_read_abort();
		wr(mode_cfg_pkg::ADDR_TIMING, 8'h0A, 16, 10);
		rchk(mode_cfg_pkg::ADDR_TIMING, 8'h0A);
		rchk(mode_cfg_pkg::ADDR_TIMING, 8'h0A);
		wr(mode_cfg_pkg::ADDR_TIMING, 8'h05, 12);
		rchk(mode_cfg_pkg::ADDR_TIMING, 8'h0A);
		wr(mode_cfg_pkg::ADDR_TIMING, 8'h03, 18);
		`CHK({clk_inv, clk_phase, dcs_on}, 4'h3)
		rchk(7'h55, 8'h00);
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge ref_clk);
		resetn <= 1'b1;
		repeat (4) @(posedge ref_clk);
		t_parallel();
		t_soft_reset();
		t_power();
		t_read_abort();
		wrap_up();
	end
endmodule // testbench
`default_nettype wire
